// >>> hdl/sam_defs.vh
// Constants for the SDRAM address multiplexer and power-on sequencer
`ifndef SAM_DEFS_VH
`define SAM_DEFS_VH

// Pin and address widths
`define SAM_PIN_W 18
`define SAM_ADDR_W 32
`define SAM_PIN_IDX_W 6

// Address pin of the lowest SDRAM address line per bus width
`define SAM_BASE_32 6'h02
`define SAM_BASE_16 6'h01

// Precharge-select line sits on SDRAM address line ten
`define SAM_AP_LINE 6'h0A
// Column command level on the precharge-select line: auto-precharge
`define SAM_AP_AUTO 1'b1

// Row and column size selects: 0 -> min, 1 -> min+1, 2 -> min+2
`define SAM_ROW_MIN 6'h0B
`define SAM_COL_MIN 6'h08
`define SAM_SEL_MAX 2'h2

// Area decode: area 3 and the cache-select bit
`define SAM_AREA_MSB 28
`define SAM_AREA_LSB 26
`define SAM_AREA3 3'h3
`define SAM_CACHE_BIT 29

// Mode-register access family
`define SAM_MODE_HI_MSB 31
`define SAM_MODE_HI_LSB 12
`define SAM_MODE_HI 20'hFFFC5
`define SAM_MODE_LO_W 12
`define SAM_M32_CL2_SW 12'h880
`define SAM_M32_CL3_SW 12'h8C0
`define SAM_M32_CL2_BW 12'h080
`define SAM_M32_CL3_BW 12'h0C0
`define SAM_M16_CL2_SW 12'h440
`define SAM_M16_CL3_SW 12'h460
`define SAM_M16_CL2_BW 12'h040
`define SAM_M16_CL3_BW 12'h060

// Commands as {cs_n, ras_n, cas_n, we_n}
`define SAM_CMD_DESEL 4'hF
`define SAM_CMD_NOP 4'h7
`define SAM_CMD_PRECHARGE_ALL_CMD 4'h2
`define SAM_CMD_REF 4'h1
`define SAM_CMD_MRS 4'h0
`define SAM_CMD_ACT 4'h3
`define SAM_CMD_READ 4'h5
`define SAM_CMD_WRIT 4'h4

// Sequence counts
`define SAM_CNT_W 4
`define SAM_REF_TIMES 4'h8
`define SAM_CNT_ZERO 4'h0
`define SAM_CNT_ONE 4'h1

// Refresh-recovery field to idle cycles
`define SAM_TRC_0 4'h2
`define SAM_TRC_1 4'h3
`define SAM_TRC_2 4'h5
`define SAM_TRC_3 4'h8

`endif

// >>> hdl/sam_addr_mux.v
// Row/column/bank multiplexer onto the external address pins
`timescale 1ns/1ps
`default_nettype none
`include "sam_defs.vh"

module sam_addr_mux (
  input wire [`SAM_ADDR_W-1:0] i_addr,
  input wire i_row_phase,
  input wire i_bus32,
  input wire [1:0] i_row_sel,
  input wire [1:0] i_col_sel,
  input wire i_ap_level,
  output wire [`SAM_PIN_W-1:0] o_pins
);

  wire [`SAM_PIN_IDX_W-1:0] base;
  wire [`SAM_PIN_IDX_W-1:0] row_n;
  wire [`SAM_PIN_IDX_W-1:0] col_n;

  assign base = i_bus32 ? `SAM_BASE_32 : `SAM_BASE_16;
  assign row_n = `SAM_ROW_MIN + {4'h0, i_row_sel};
  assign col_n = `SAM_COL_MIN + {4'h0, i_col_sel};

  genvar p;
  generate
    for (p = 0; p < `SAM_PIN_W; p = p + 1)
    begin : g_pin
      localparam [`SAM_PIN_IDX_W-1:0] PIN = p;
      wire [`SAM_PIN_IDX_W-1:0] line;
      wire [`SAM_PIN_IDX_W-1:0] shifted;
      wire used;
      wire is_bank;
      assign line = PIN - base;
      assign shifted = PIN + col_n;
      assign used = (PIN >= base) && (line < row_n + 6'h02);
      assign is_bank = (line >= row_n);
      // Row phase: bit p+col; column phase: bit p, banks kept, line ten fixed
      assign o_pins[p] = !used ? 1'b0 :
                         (i_row_phase || is_bank) ? i_addr[shifted[4:0]] :
                         (line == `SAM_AP_LINE) ? i_ap_level :
                         i_addr[p];
    end
  endgenerate

endmodule
`default_nettype wire

// >>> hdl/sam_ctrl.v
// SDRAM area-3 controller core: access decode, address pins, power-on mode set
`timescale 1ns/1ps
`default_nettype none
`include "sam_defs.vh"


module sam_ctrl (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_req,
  input wire [`SAM_ADDR_W-1:0] i_addr,
  input wire i_write,
  input wire i_size16,
  input wire i_bus32,
  input wire [1:0] i_row_sel,
  input wire [1:0] i_col_sel,
  input wire [1:0] i_precharge_wait_field,
  input wire [1:0] i_refresh_recovery_field,
  output wire o_ready,
  output reg o_done,
  output reg o_ignored,
  output reg o_init_done,
  output reg o_uncached,
  output wire o_area3_chip_select_n,
  output wire o_ras_n,
  output wire o_cas_n,
  output wire o_we_n,
  output wire [`SAM_PIN_W-1:0] o_addr
);

  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_PRECHARGE_ALL_CMD = 10'h002;
  localparam [9:0] S_PWAIT = 10'h004;
  localparam [9:0] S_REF = 10'h008;
  localparam [9:0] S_RWAIT = 10'h010;
  localparam [9:0] S_MRS = 10'h020;
  localparam [9:0] S_ACT = 10'h040;
  localparam [9:0] S_COL = 10'h080;
  localparam [9:0] S_APW = 10'h100;
  localparam [9:0] S_DONE = 10'h200;

  reg [9:0] state_q;
  reg [9:0] state_d;
  reg [`SAM_CNT_W-1:0] cnt_q;
  reg [`SAM_CNT_W-1:0] cnt_d;
  reg [`SAM_CNT_W-1:0] ref_q;
  reg [`SAM_CNT_W-1:0] ref_d;
  reg [`SAM_ADDR_W-1:0] addr_q;
  reg write_q;
  reg [3:0] cmd_q;
  reg [3:0] cmd_d;
  reg [`SAM_PIN_W-1:0] pins_q;
  reg [`SAM_PIN_W-1:0] pins_d;
  reg ignored_d;

  wire take;
  wire in_area3;
  wire mode_page;
  wire [`SAM_MODE_LO_W-1:0] mode_lo;
  wire mode_hit32;
  wire mode_hit16;
  wire mode_hit;
  wire [3:0] hit32_v;
  wire [3:0] hit16_v;
  wire size_ok;
  wire row_phase;
  wire [`SAM_PIN_W-1:0] mux_pins;
  wire [`SAM_PIN_W-1:0] mode_pins;
  wire [`SAM_CNT_W-1:0] pw_cycles;
  reg [`SAM_CNT_W-1:0] rc_cycles;

  // Requests are only taken in idle, so a mode set blocks all access
  assign o_ready = (state_q == S_IDLE);
  assign take = i_req && o_ready;

  assign in_area3 = (i_addr[`SAM_AREA_MSB:`SAM_AREA_LSB] == `SAM_AREA3);
  assign mode_page = (i_addr[`SAM_MODE_HI_MSB:`SAM_MODE_HI_LSB] == `SAM_MODE_HI);
  assign mode_lo = i_addr[`SAM_MODE_LO_W-1:0];

  // One compare per mode-address entry; the bus width picks the family
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_mode
      wire [`SAM_MODE_LO_W-1:0] code32;
      wire [`SAM_MODE_LO_W-1:0] code16;
      assign code32 = (k == 0) ? `SAM_M32_CL2_SW :
                      (k == 1) ? `SAM_M32_CL3_SW :
                      (k == 2) ? `SAM_M32_CL2_BW :
                      `SAM_M32_CL3_BW;
      assign code16 = (k == 0) ? `SAM_M16_CL2_SW :
                      (k == 1) ? `SAM_M16_CL3_SW :
                      (k == 2) ? `SAM_M16_CL2_BW :
                      `SAM_M16_CL3_BW;
      assign hit32_v[k] = (mode_lo == code32);
      assign hit16_v[k] = (mode_lo == code16);
    end
  endgenerate

  assign mode_hit32 = i_bus32 && (|hit32_v);
  assign mode_hit16 = !i_bus32 && (|hit16_v);
  // Only a 16-bit write starts the sequence; the data is not looked at
  assign mode_hit = mode_page && i_write && i_size16 && (mode_hit32 || mode_hit16);

  // Sizes beyond 13 rows or 10 columns are not accepted
  assign size_ok = (i_row_sel <= `SAM_SEL_MAX) && (i_col_sel <= `SAM_SEL_MAX);

  assign pw_cycles = {2'h0, i_precharge_wait_field};

  always @*
  begin
    case (i_refresh_recovery_field)
      2'h0: rc_cycles = `SAM_TRC_0;
      2'h1: rc_cycles = `SAM_TRC_1;
      2'h2: rc_cycles = `SAM_TRC_2;
      default: rc_cycles = `SAM_TRC_3;
    endcase
  end

  // The activate command carries the row; every later command carries the column
  assign row_phase = (state_q == S_ACT);

  // Column and precharge-all phases both raise line ten
  sam_addr_mux u_mux (
    .i_addr(take ? i_addr : addr_q),
    .i_row_phase(row_phase),
    .i_bus32(i_bus32),
    .i_row_sel(i_row_sel),
    .i_col_sel(i_col_sel),
    .i_ap_level(`SAM_AP_AUTO),
    .o_pins(mux_pins)
  );

  // Mode value is the low address portion of the trigger address
  assign mode_pins = {6'h00, addr_q[`SAM_MODE_LO_W-1:0]};

  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    ref_d = ref_q;
    cmd_d = `SAM_CMD_NOP;
    pins_d = pins_q;
    ignored_d = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        cmd_d = `SAM_CMD_DESEL;
        if (take)
        begin
          if (mode_hit)
          begin
            state_d = S_PRECHARGE_ALL_CMD;
          end
          else if (in_area3 && size_ok && o_init_done)
          begin
            state_d = S_ACT;
          end
          else
          begin
            state_d = S_DONE;
            ignored_d = 1'b1;
          end
        end
      end
      S_PRECHARGE_ALL_CMD:
      begin
        cmd_d = `SAM_CMD_PRECHARGE_ALL_CMD;
        pins_d = mux_pins;
        ref_d = `SAM_REF_TIMES;
        cnt_d = pw_cycles;
        state_d = (pw_cycles == `SAM_CNT_ZERO) ? S_REF : S_PWAIT;
      end
      S_PWAIT:
      begin
        cnt_d = cnt_q - `SAM_CNT_ONE;
        if (cnt_q == `SAM_CNT_ONE)
        begin
          state_d = S_REF;
        end
      end
      S_REF:
      begin
        cmd_d = `SAM_CMD_REF;
        ref_d = ref_q - `SAM_CNT_ONE;
        cnt_d = rc_cycles;
        state_d = S_RWAIT;
      end
      S_RWAIT:
      begin
        cnt_d = cnt_q - `SAM_CNT_ONE;
        if (cnt_q == `SAM_CNT_ONE)
        begin
          state_d = (ref_q == `SAM_CNT_ZERO) ? S_MRS : S_REF;
        end
      end
      S_MRS:
      begin
        cmd_d = `SAM_CMD_MRS;
        pins_d = mode_pins;
        state_d = S_DONE;
      end
      S_ACT:
      begin
        cmd_d = `SAM_CMD_ACT;
        pins_d = mux_pins;
        state_d = S_COL;
      end
      S_COL:
      begin
        // One command per access: burst length one in both write modes
        cmd_d = write_q ? `SAM_CMD_WRIT : `SAM_CMD_READ;
        pins_d = mux_pins;
        cnt_d = pw_cycles;
        state_d = (pw_cycles == `SAM_CNT_ZERO) ? S_DONE : S_APW;
      end
      S_APW:
      begin
        cnt_d = cnt_q - `SAM_CNT_ONE;
        if (cnt_q == `SAM_CNT_ONE)
        begin
          state_d = S_DONE;
        end
      end
      S_DONE:
      begin
        cmd_d = `SAM_CMD_DESEL;
        state_d = S_IDLE;
      end
      default:
      begin
        cmd_d = `SAM_CMD_DESEL;
        state_d = S_IDLE;
      end
    endcase
  end

  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= S_IDLE;
      cnt_q <= `SAM_CNT_ZERO;
      ref_q <= `SAM_CNT_ZERO;
      addr_q <= {`SAM_ADDR_W{1'b0}};
      write_q <= 1'b0;
      cmd_q <= `SAM_CMD_DESEL;
      pins_q <= {`SAM_PIN_W{1'b0}};
      o_done <= 1'b0;
      o_ignored <= 1'b0;
      o_init_done <= 1'b0;
      o_uncached <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ref_q <= ref_d;
      cmd_q <= cmd_d;
      pins_q <= pins_d;
      if (take)
      begin
        addr_q <= i_addr;
        write_q <= i_write;
        o_uncached <= i_addr[`SAM_CACHE_BIT];
      end
      o_done <= (state_q == S_DONE);
      if (take)
      begin
        o_ignored <= ignored_d;
      end
      // Sequence ends with all banks idle after the refreshes
      if (state_q == S_MRS)
      begin
        o_init_done <= 1'b1;
      end
    end
  end

  assign o_area3_chip_select_n = cmd_q[3];
  assign o_ras_n = cmd_q[2];
  assign o_cas_n = cmd_q[1];
  assign o_we_n = cmd_q[0];
  assign o_addr = pins_q;

endmodule
`default_nettype wire

// >>> tb/sam_ctrl_chk.sv
// Port checker for the SDRAM area-3 controller
`timescale 1ns/1ps
`default_nettype none
`include "sam_defs.vh"
module sam_ctrl_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic i_bus32,
  input wire logic [1:0] i_precharge_wait_field,
  input wire logic [1:0] i_refresh_recovery_field,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_ignored,
  input wire logic o_init_done,
  input wire logic o_uncached,
  input wire logic o_area3_chip_select_n,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic [17:0] o_addr
);
  wire [3:0] c = {o_area3_chip_select_n, o_ras_n, o_cas_n, o_we_n};
  wire ap = i_bus32 ? o_addr[12] : o_addr[11];
  wire col = c == `SAM_CMD_READ || c == `SAM_CMD_WRIT;
  wire [1:0] pw = i_precharge_wait_field;
  wire [1:0] rr = i_refresh_recovery_field;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_done_ready: assert property (o_done |-> o_ready)
    else $error("done while busy");
  chk_precharge_all_cmd_line: assert property (c == `SAM_CMD_PRECHARGE_ALL_CMD |-> ap)
    else $error("precharge-all with line ten low");
  chk_col_line: assert property (col |-> ap)
    else $error("column command with line ten low");
  chk_precharge_all_cmd_wait: assert property (c == `SAM_CMD_PRECHARGE_ALL_CMD && pw == 2'h2 |=>
    c == `SAM_CMD_NOP [*2] ##1 c == `SAM_CMD_REF) else $error("precharge wait wrong");
  chk_ref_gap: assert property (c == `SAM_CMD_REF && rr == 2'h3 |=>
    c == `SAM_CMD_NOP [*8] ##1 (c == `SAM_CMD_REF || c == `SAM_CMD_MRS))
    else $error("refresh recovery wrong");
  chk_mrs_end: assert property (c == `SAM_CMD_MRS |=>
    o_done && o_init_done && c == `SAM_CMD_DESEL) else $error("mode set end wrong");
  chk_ign_quiet: assert property (i_req && o_ready ##1 o_ignored |->
    c == `SAM_CMD_DESEL ##1 o_done) else $error("ignored request not quiet");
  chk_act_col: assert property (c == `SAM_CMD_ACT |-> o_init_done ##1 col)
    else $error("activate not followed by one column command");
  chk_uncached: assert property (i_req && o_ready |=> o_uncached == $past(i_addr[29]))
    else $error("cache select wrong");
  chk_mrs_pins: assert property (c == `SAM_CMD_MRS |-> o_addr[17:12] == 6'h00)
    else $error("mode value high pins set");
endmodule
bind sam_ctrl sam_ctrl_chk u_chk (.i_clk_sys, .i_rst, .i_req, .i_addr, .i_bus32,
  .i_precharge_wait_field, .i_refresh_recovery_field, .o_ready, .o_done, .o_ignored,
  .o_init_done, .o_uncached, .o_area3_chip_select_n, .o_ras_n, .o_cas_n, .o_we_n, .o_addr);
`default_nettype wire

// >>> tb/sam_sdram_model.sv
// Behavioural SDRAM model recording what each command carried
`timescale 1ns/1ps
`default_nettype none
`include "sam_defs.vh"
module sam_sdram_model (
  input wire logic i_clk_sys,
  input wire logic [3:0] i_cmd,
  input wire logic [17:0] i_addr,
  output logic [3:0] o_refs,
  output logic [17:0] o_mode,
  output logic [17:0] o_row,
  output logic [17:0] o_col,
  output logic [3:0] o_col_cmd
);
  always @(posedge i_clk_sys)
  begin
    case (i_cmd)
      `SAM_CMD_PRECHARGE_ALL_CMD: o_refs <= 4'h0;
      `SAM_CMD_REF: o_refs <= o_refs + 4'h1;
      `SAM_CMD_MRS: o_mode <= i_addr;
      `SAM_CMD_ACT: o_row <= i_addr;
      `SAM_CMD_READ, `SAM_CMD_WRIT:
      begin
        o_col <= i_addr;
        o_col_cmd <= i_cmd;
      end
      default: o_col_cmd <= o_col_cmd;
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/tb_sam_ctrl.sv
// Self-checking bench for the SDRAM area-3 controller
`timescale 1ns/1ps
`default_nettype none
`include "sam_defs.vh"
module tb_sam_ctrl;
  localparam logic [31:0] ad = 32'h2DA55A5C;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [31:0] addr = 32'h0;
  logic wr = 1'b0;
  logic sz = 1'b0;
  logic b32 = 1'b1;
  logic [1:0] rs = 2'h2;
  logic [1:0] cs = 2'h1;
  logic [1:0] pw = 2'h1;
  logic [1:0] rr = 2'h0;
  wire o_ready, o_done, o_ignored, o_init_done, o_uncached;
  wire [3:0] c;
  wire [3:0] refs;
  wire [3:0] ccmd;
  wire [17:0] o_addr, mode, row, col;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  int trc_t [4] = '{2, 3, 5, 8};
  logic [11:0] lo_t [8] = '{12'h880, 12'h8C0, 12'h080, 12'h0C0,
    12'h440, 12'h460, 12'h040, 12'h060};
  sam_ctrl dut (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_addr(addr), .i_write(wr),
    .i_size16(sz), .i_bus32(b32), .i_row_sel(rs), .i_col_sel(cs),
    .i_precharge_wait_field(pw), .i_refresh_recovery_field(rr), .o_ready, .o_done,
    .o_ignored, .o_init_done, .o_uncached, .o_area3_chip_select_n(c[3]), .o_ras_n(c[2]),
    .o_cas_n(c[1]), .o_we_n(c[0]), .o_addr);
  sam_sdram_model m (.i_clk_sys(clk), .i_cmd(c), .i_addr(o_addr), .o_refs(refs),
    .o_mode(mode), .o_row(row), .o_col(col), .o_col_cmd(ccmd));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request; n ends as the edge count from take to done
  task automatic run(input logic [31:0] a, input logic w, input logic s);
    @(posedge clk);
    #1;
    addr = a;
    wr = w;
    sz = s;
    req = 1'b1;
    @(posedge clk);
    #1;
    req = 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (o_done !== 1'b1 && n < 200);
  endtask
  task automatic ign_case(input logic [31:0] a, input logic w, input logic s, input logic e);
    run(a, w, s);
    check(n, 1);
    check({o_ignored, o_init_done}, {1'b1, e});
  endtask
  task automatic t_pre();
    check({c, o_ready, o_done, o_ignored, o_init_done, o_uncached}, 9'h1F0);
    check(o_addr, 32'h0);
    ign_case(ad, 1'b1, 1'b0, 1'b0);
    $display("reset and early access test done");
  endtask
  task automatic t_mode();
    repeat (8) @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      b32 = (i < 4);
      pw = i[1:0];
      rr = ~i[1:0];
      run({20'hFFFC5, lo_t[i]}, 1'b1, 1'b1);
      check(n, 3 + pw + 8 * (1 + trc_t[rr]));
      check(refs, 8);
      check(mode, {6'h0, lo_t[i]});
      check({o_init_done, o_ignored}, 2'b10);
    end
    $display("mode set test done");
  endtask
  task automatic t_access();
    b32 = 1'b1;
    pw = 2'h1;
    for (int w = 0; w < 2; w++)
    begin
      run(ad, w[0], 1'b0);
      check(n, 4);
      check(row, (ad >> 9) & 32'h1FFFC);
      check(col, (ad & 32'h06FFC) | 32'h1000 | ((ad >> 9) & 32'h18000));
      check(ccmd, w ? `SAM_CMD_WRIT : `SAM_CMD_READ);
      check({o_uncached, o_ignored}, 2'b10);
    end
    rs = 2'h0;
    cs = 2'h0;
    run(ad, 1'b1, 1'b0);
    check(row, (ad >> 8) & 32'h7FFC);
    rs = 2'h2;
    $display("access test done");
  endtask
  task automatic t_ign();
    cs = 2'h3;
    ign_case(ad, 1'b1, 1'b0, 1'b1);
    cs = 2'h1;
    ign_case(32'h10001000, 1'b1, 1'b1, 1'b1);
    ign_case(32'hFFFC5880, 1'b0, 1'b1, 1'b1);
    ign_case(32'hFFFC5880, 1'b1, 1'b0, 1'b1);
    check(mode, 32'h00060);
    $display("ignored request test done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_pre();
    t_mode();
    t_access();
    t_ign();
    results();
  end
endmodule
`default_nettype wire
